// ==== bcb_pkg.sv ====
/*
  Shared types and constants of the bit-carry and branch-condition unit.
  Assumes a decoder that presents decoded requests on the core clock.
*/
package bcb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 24;
  localparam int BYTE_W = 8;
  localparam int POS_W = 3;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  // Single-bit carry operations; codes above the last one are illegal.
  typedef enum logic [3:0] {
    bit_and_carry,
    bit_inv_and_carry,
    bit_or_carry,
    bit_inv_or_carry,
    bit_xor_carry,
    bit_inv_xor_carry,
    bit_load_carry,
    bit_inv_load_carry,
    bit_store_carry,
    bit_inv_store_carry
  } bcb_bit_op_t;

  // Program flow operations; codes above the last one are illegal.
  typedef enum logic [2:0] {
    flow_branch_cond,
    jump_unconditional,
    branch_to_subroutine,
    jump_to_subroutine,
    return_from_subroutine
  } bcb_flow_op_t;

  // Sixteen branch conditions, in condition-field order.
  typedef enum logic [3:0] {
    branch_always,
    branch_never,
    branch_high,
    branch_low_or_same,
    branch_carry_clear,
    branch_carry_set,
    branch_not_equal,
    branch_equal,
    branch_overflow_clear,
    branch_overflow_set,
    branch_plus,
    branch_minus,
    branch_greater_equal,
    branch_less_than,
    branch_greater_than,
    branch_less_equal
  } bcb_cond_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bcb_flags_t;

  typedef struct packed {
    bcb_bit_op_t op;
    logic use_reg;
    logic [POS_W-1:0] imm;
    logic [POS_W-1:0] reg_num;
    logic [BYTE_W-1:0] operand;
  } bcb_bit_req_t;

  typedef struct packed {
    logic carry_we;
    logic carry;
    logic byte_we;
    logic [BYTE_W-1:0] data;
  } bcb_bit_rsp_t;

  typedef struct packed {
    bcb_flow_op_t op;
    bcb_cond_t cond;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] saved_addr;
  } bcb_flow_req_t;

  typedef struct packed {
    logic pc_load;
    logic [PC_W-1:0] pc;
    logic push;
    logic [PC_W-1:0] push_addr;
  } bcb_flow_rsp_t;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam bcb_bit_rsp_t BIT_RSP_RST = '0;
  localparam bcb_flow_rsp_t FLOW_RSP_RST = '0;

endpackage : bcb_pkg

// ==== bcb_cond_eval.sv ====
/*
  Branch condition evaluator: decides from the flags whether a condition holds.
  Assumes flags that are stable during the cycle in which they are sampled.
*/
`timescale 1ns/1ps

module bcb_cond_eval (
  // Inputs.
  input wire bcb_pkg::bcb_flags_t i_flags,
  input wire bcb_pkg::bcb_cond_t i_cond,
  // Result.
  output logic o_true
);

  logic nv;

  // ----------------------------------------------------------------
  // Condition table
  // ----------------------------------------------------------------
  // Signed conditions share the sign-versus-overflow term.
  assign nv = i_flags.n ^ i_flags.v;

  // Every code of the field is a legal condition.
  always_comb begin
    unique case (i_cond)
      bcb_pkg::branch_always: o_true = 1'b1;
      bcb_pkg::branch_never: o_true = 1'b0;
      bcb_pkg::branch_high: o_true = ~(i_flags.c | i_flags.z);
      bcb_pkg::branch_low_or_same: o_true = i_flags.c | i_flags.z;
      bcb_pkg::branch_carry_clear: o_true = ~i_flags.c;
      bcb_pkg::branch_carry_set: o_true = i_flags.c;
      bcb_pkg::branch_not_equal: o_true = ~i_flags.z;
      bcb_pkg::branch_equal: o_true = i_flags.z;
      bcb_pkg::branch_overflow_clear: o_true = ~i_flags.v;
      bcb_pkg::branch_overflow_set: o_true = i_flags.v;
      bcb_pkg::branch_plus: o_true = ~i_flags.n;
      bcb_pkg::branch_minus: o_true = i_flags.n;
      bcb_pkg::branch_greater_equal: o_true = ~nv;
      bcb_pkg::branch_less_than: o_true = nv;
      bcb_pkg::branch_greater_than: o_true = ~(i_flags.z | nv);
      bcb_pkg::branch_less_equal: o_true = i_flags.z | nv;
    endcase
  end

endmodule : bcb_cond_eval

// ==== bcb_core.sv ====
/*
  Bit-carry and branch-condition unit of the processor core.
  Assumes the decoder presents one-cycle request strobes, the condition flags,
  and the byte operand already fetched; answers appear one edge later.
*/
`timescale 1ns/1ps

module bcb_core (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Condition flags from the condition code register.
  input wire bcb_pkg::bcb_flags_t i_flags,
  // Bit operation request.
  input wire logic i_bit_valid,
  input wire bcb_pkg::bcb_bit_req_t i_bit,
  // Program flow request.
  input wire logic i_flow_valid,
  input wire bcb_pkg::bcb_flow_req_t i_flow,
  // Answers.
  output bcb_pkg::bcb_bit_rsp_t o_bit,
  output bcb_pkg::bcb_flow_rsp_t o_flow
);

  // ----------------------------------------------------------------
  // Bit selection
  // ----------------------------------------------------------------
  logic inv_op;
  logic [bcb_pkg::POS_W-1:0] pos;
  logic sel;
  logic [bcb_pkg::BYTE_W-1:0] stored;
  bcb_pkg::bcb_bit_rsp_t next_bit;

  // Inverted variants ignore the register-sourced bit number.
  always_comb begin
    unique case (i_bit.op)
      bcb_pkg::bit_inv_and_carry,
      bcb_pkg::bit_inv_or_carry,
      bcb_pkg::bit_inv_xor_carry,
      bcb_pkg::bit_inv_load_carry,
      bcb_pkg::bit_inv_store_carry: inv_op = 1'b1;
      default: inv_op = 1'b0;
    endcase
  end

  assign pos = (i_bit.use_reg && !inv_op) ? i_bit.reg_num : i_bit.imm;

  assign sel = i_bit.operand[pos];

  // ----------------------------------------------------------------
  // Bit operation results
  // ----------------------------------------------------------------
  // Computes the next carry and byte write; illegal codes write nothing.
  always_comb begin
    next_bit = bcb_pkg::BIT_RSP_RST;
    stored = i_bit.operand;
    if (i_bit_valid) begin
      unique case (i_bit.op)
        bcb_pkg::bit_and_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = i_flags.c & sel;
        end
        bcb_pkg::bit_inv_and_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = i_flags.c & ~sel;
        end
        bcb_pkg::bit_or_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = i_flags.c | sel;
        end
        bcb_pkg::bit_inv_or_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = i_flags.c | ~sel;
        end
        bcb_pkg::bit_xor_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = i_flags.c ^ sel;
        end
        bcb_pkg::bit_inv_xor_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = i_flags.c ^ ~sel;
        end
        bcb_pkg::bit_load_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = sel;
        end
        bcb_pkg::bit_inv_load_carry: begin
          next_bit.carry_we = 1'b1;
          next_bit.carry = ~sel;
        end
        bcb_pkg::bit_store_carry: begin
          stored[pos] = i_flags.c;
          next_bit.byte_we = 1'b1;
          next_bit.data = stored;
        end
        bcb_pkg::bit_inv_store_carry: begin
          stored[pos] = ~i_flags.c;
          next_bit.byte_we = 1'b1;
          next_bit.data = stored;
        end
        default: begin
          next_bit = bcb_pkg::BIT_RSP_RST;
        end
      endcase
    end
  end

  // Registers the bit answer.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bit <= bcb_pkg::BIT_RSP_RST;
    end else begin
      o_bit <= next_bit;
    end
  end

  // ----------------------------------------------------------------
  // Program flow
  // ----------------------------------------------------------------
  logic cond_true;
  bcb_pkg::bcb_flow_rsp_t next_flow;

  // Evaluates the branch condition from the current flags.
  bcb_cond_eval u_cond (
    .i_flags(i_flags),
    .i_cond(i_flow.cond),
    .o_true(cond_true)
  );

  // Computes the program counter load and the return-address push.
  always_comb begin
    next_flow = o_flow;
    next_flow.pc_load = 1'b0;
    next_flow.push = 1'b0;
    if (i_flow_valid) begin
      unique case (i_flow.op)
        bcb_pkg::flow_branch_cond: begin
          next_flow.pc_load = cond_true;
          if (cond_true) begin
            next_flow.pc = i_flow.target;
          end
        end
        bcb_pkg::jump_unconditional: begin
          next_flow.pc_load = 1'b1;
          next_flow.pc = i_flow.target;
        end
        bcb_pkg::branch_to_subroutine,
        bcb_pkg::jump_to_subroutine: begin
          next_flow.push = 1'b1;
          next_flow.push_addr = i_flow.ret_addr;
          next_flow.pc_load = 1'b1;
          next_flow.pc = i_flow.target;
        end
        bcb_pkg::return_from_subroutine: begin
          next_flow.pc_load = 1'b1;
          next_flow.pc = i_flow.saved_addr;
        end
        default: begin
          next_flow.pc_load = 1'b0;
        end
      endcase
    end
  end

  // Registers the flow answer; the address fields hold between loads.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flow <= bcb_pkg::FLOW_RSP_RST;
    end else begin
      o_flow <= next_flow;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic chk_imm_bit;
  logic chk_any_bit;

  // Helper bits taken straight from the request fields.
  assign chk_imm_bit = i_bit.operand[i_bit.imm];
  assign chk_any_bit = i_bit.use_reg ? i_bit.operand[i_bit.reg_num] : chk_imm_bit;

  property p_xor;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_xor_carry
    |=> o_bit.carry_we && o_bit.carry == ($past(i_flags.c) ^ $past(chk_any_bit));
  endproperty
  a_xor: assert property (p_xor) else $error("bit xor carry wrong");

  property p_inv_xor;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_inv_xor_carry
    |=> o_bit.carry == ($past(i_flags.c) ^ !$past(chk_imm_bit));
  endproperty
  a_inv_xor: assert property (p_inv_xor) else $error("inverted xor carry wrong");

  property p_load;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_load_carry
    |=> o_bit.carry_we && !o_bit.byte_we && o_bit.carry == $past(chk_any_bit);
  endproperty
  a_load: assert property (p_load) else $error("bit load carry wrong");

  property p_inv_load;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_inv_load_carry
    |=> o_bit.carry != $past(chk_imm_bit);
  endproperty
  a_inv_load: assert property (p_inv_load) else $error("inverted load wrong");

  property p_store;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_store_carry && !i_bit.use_reg
    |=> o_bit.byte_we && !o_bit.carry_we
        && o_bit.data[$past(i_bit.imm)] == $past(i_flags.c)
        && (o_bit.data ^ $past(i_bit.operand)) == (($past(i_bit.operand[i_bit.imm]) ^ $past(i_flags.c))
            ? (8'h01 << $past(i_bit.imm)) : 8'h00);
  endproperty
  a_store: assert property (p_store) else $error("bit store wrong");

  property p_inv_store;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_inv_store_carry
    |=> o_bit.byte_we && o_bit.data[$past(i_bit.imm)] == !$past(i_flags.c);
  endproperty
  a_inv_store: assert property (p_inv_store) else $error("inverted store wrong");

  property p_imm_only;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_bit_valid && i_bit.op == bcb_pkg::bit_inv_load_carry && i_bit.use_reg
    |=> o_bit.carry == !$past(chk_imm_bit);
  endproperty
  a_imm_only: assert property (p_imm_only) else $error("register bit number used");

  property p_never;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_flow_valid && i_flow.op == bcb_pkg::flow_branch_cond
    && (i_flow.cond == bcb_pkg::branch_never || i_flow.cond == bcb_pkg::branch_always)
    |=> o_flow.pc_load == ($past(i_flow.cond) == bcb_pkg::branch_always) && !o_flow.push;
  endproperty
  a_never: assert property (p_never) else $error("always or never branch wrong");

  property p_high;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_flow_valid && i_flow.op == bcb_pkg::flow_branch_cond && i_flow.cond == bcb_pkg::branch_high
    |=> o_flow.pc_load == !($past(i_flags.c) || $past(i_flags.z));
  endproperty
  a_high: assert property (p_high) else $error("high condition wrong");

  property p_equal;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_flow_valid && i_flow.op == bcb_pkg::flow_branch_cond && i_flow.cond == bcb_pkg::branch_equal
    |=> o_flow.pc_load == $past(i_flags.z);
  endproperty
  a_equal: assert property (p_equal) else $error("equal condition wrong");

  property p_greater;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_flow_valid && i_flow.op == bcb_pkg::flow_branch_cond && i_flow.cond == bcb_pkg::branch_greater_than
    |=> o_flow.pc_load == !($past(i_flags.z) || ($past(i_flags.n) != $past(i_flags.v)));
  endproperty
  a_greater: assert property (p_greater) else $error("greater-than condition wrong");

  property p_jump;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_flow_valid && i_flow.op == bcb_pkg::jump_unconditional
    |=> o_flow.pc_load && o_flow.pc == $past(i_flow.target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump did not load target");

  property p_call;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_flow_valid && i_flow.op == bcb_pkg::branch_to_subroutine
    |=> o_flow.push && o_flow.push_addr == $past(i_flow.ret_addr) && o_flow.pc == $past(i_flow.target)
    ##1 o_flow.push == $past(i_flow_valid
        && (i_flow.op == bcb_pkg::branch_to_subroutine || i_flow.op == bcb_pkg::jump_to_subroutine));
  endproperty
  a_call: assert property (p_call) else $error("subroutine call wrong");

endmodule : bcb_core

// ==== bcb_core_tb_top.sv ====
/*
  Self-checking testbench of the bit-carry and branch-condition unit.
  Assumes bcb_pkg and bcb_core are compiled before this file.
*/
`timescale 1ns/1ps

module bcb_core_tb_top;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk;
  logic i_rst_n;
  bcb_pkg::bcb_flags_t i_flags;
  logic i_bit_valid;
  bcb_pkg::bcb_bit_req_t i_bit;
  logic i_flow_valid;
  bcb_pkg::bcb_flow_req_t i_flow;
  bcb_pkg::bcb_bit_rsp_t o_bit;
  bcb_pkg::bcb_flow_rsp_t o_flow;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [23:0] exp_pc;
  logic [23:0] exp_push;

  // One comparison: counts it and reports a difference at once.
  `define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

  // ----------------------------------------------------------------
  // Clock, design and watchdog
  // ----------------------------------------------------------------
  // The clock toggles every half period of 2.5 ns.
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  bcb_core dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flags(i_flags),
    .i_bit_valid(i_bit_valid),
    .i_bit(i_bit),
    .i_flow_valid(i_flow_valid),
    .i_flow(i_flow),
    .o_bit(o_bit),
    .o_flow(o_flow)
  );

  // A hang is cut short well after the expected run of some 700 cycles.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("Timeout after %0d cycles.", cycles);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Reference functions
  // ----------------------------------------------------------------
  // Carry result of a carry-combining op; odd codes invert the bit first.
  function automatic logic bit_res(input logic [3:0] op, input logic c, input logic b);
    logic v;
    v = op[0] ? ~b : b;
    case (op[3:1])
      3'h0: bit_res = c & v;
      3'h1: bit_res = c | v;
      3'h2: bit_res = c ^ v;
      default: bit_res = v;
    endcase
  endfunction : bit_res

  // Condition truth from flags {n, z, v, c}; odd codes are the opposite test.
  function automatic logic cond_ok(input logic [3:0] k, input logic [3:0] f);
    logic n, z, v, c, r;
    {n, z, v, c} = f;
    case (k[3:1])
      3'h0: r = 1'h1;
      3'h1: r = ~(c | z);
      3'h2: r = ~c;
      3'h3: r = ~z;
      3'h4: r = ~v;
      3'h5: r = ~n;
      3'h6: r = ~(n ^ v);
      default: r = ~(z | (n ^ v));
    endcase
    cond_ok = r ^ k[0];
  endfunction : cond_ok

  // ----------------------------------------------------------------
  // Drivers, entered at a falling edge
  // ----------------------------------------------------------------
  // Presents one bit op and checks the answer one edge later.
  task automatic bit_op(input logic [3:0] op, input logic ur, input logic [2:0] imm,
      input logic [2:0] rn, input logic [7:0] opd, input logic c);
    logic [2:0] pos;
    logic [7:0] d;
    bcb_pkg::bcb_bit_rsp_t e;
    pos = (op[0] || !ur) ? imm : rn;
    d = opd;
    d[pos] = op[0] ? ~c : c;
    e = bcb_pkg::BIT_RSP_RST;
    // Illegal codes above the inverted store leave the answer at rest.
    if (op inside {4'h8, 4'h9}) begin
      e.byte_we = 1'h1;
      e.data = d;
    end else if (op < 4'h8) begin
      e.carry_we = 1'h1;
      e.carry = bit_res(op, c, opd[pos]);
    end
    i_bit_valid = 1'h1;
    i_bit.op = bcb_pkg::bcb_bit_op_t'(op);
    i_bit.use_reg = ur;
    i_bit.imm = imm;
    i_bit.reg_num = rn;
    i_bit.operand = opd;
    i_flags.c = c;
    @(negedge i_clk);
    `CHK(o_bit, e)
  endtask : bit_op

  // Presents one flow request and checks the answer one edge later.
  task automatic flow_op(input logic [2:0] op, input logic [3:0] cond, input logic [3:0] f,
      input logic [23:0] tgt, input logic [23:0] ret, input logic [23:0] sav);
    bcb_pkg::bcb_flow_rsp_t e;
    e.pc_load = (op == 3'h0) ? cond_ok(cond, f) : (op <= 3'h4);
    e.push = (op == 3'h2) || (op == 3'h3);
    if (e.pc_load) begin
      exp_pc = (op == 3'h4) ? sav : tgt;
    end
    if (e.push) begin
      exp_push = ret;
    end
    e.pc = exp_pc;
    e.push_addr = exp_push;
    i_flow_valid = 1'h1;
    i_flow.op = bcb_pkg::bcb_flow_op_t'(op);
    i_flow.cond = bcb_pkg::bcb_cond_t'(cond);
    i_flow.target = tgt;
    i_flow.ret_addr = ret;
    i_flow.saved_addr = sav;
    i_flags = bcb_pkg::bcb_flags_t'(f);
    @(negedge i_clk);
    `CHK(o_flow, e)
  endtask : flow_op

  // Drops both strobes, checks that the pulses end, and reports the test.
  task automatic finish_test(input string name);
    i_bit_valid = 1'h0;
    i_flow_valid = 1'h0;
    @(negedge i_clk);
    `CHK(o_bit, bcb_pkg::BIT_RSP_RST)
    `CHK({o_flow.pc_load, o_flow.push}, 2'h0)
    $display("Test %s finished.", name);
  endtask : finish_test

  // Runs op codes lo to hi over every bit number and both carry values.
  task automatic run_bits(input int lo, input int hi, input logic ur);
    logic [2:0] p;
    for (int k = lo; k <= hi; k++) begin
      for (int j = 0; j < 16; j++) begin
        p = 3'(j >> 1);
        bit_op(4'(k), ur, p, ~p, 8'h6C ^ 8'(k), j[0]);
      end
    end
  endtask : run_bits

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every carry op, immediate bit number, back to back.
  task automatic test_carry_ops();
    run_bits(0, 7, 1'h0);
    finish_test("carry_ops");
  endtask : test_carry_ops

  // Both store kinds on every bit number of the byte, then the illegal codes.
  task automatic test_store_ops();
    run_bits(8, 15, 1'h0);
    finish_test("store_ops");
  endtask : test_store_ops

  // Register bit number differs from the immediate; inverted ops must ignore it.
  task automatic test_reg_select();
    run_bits(0, 9, 1'h1);
    finish_test("reg_select");
  endtask : test_reg_select

  // All sixteen conditions against all sixteen flag patterns.
  task automatic test_conditions();
    for (int k = 0; k < 16; k++) begin
      for (int f = 0; f < 16; f++) begin
        flow_op(3'h0, 4'(k), 4'(f), 24'hC00000 + 24'(k * 16 + f), 24'h0, 24'h0);
      end
    end
    finish_test("conditions");
  endtask : test_conditions

  // Jumps under every flag pattern, calls, a return and illegal codes.
  task automatic test_flow_ops();
    for (int f = 0; f < 16; f++) begin
      flow_op(3'h1, 4'h1, 4'(f), 24'hA00000 + 24'(f), 24'h0, 24'h0);
    end
    flow_op(3'h2, 4'h1, 4'h0, 24'h123456, 24'h0ABCDE, 24'h0);
    flow_op(3'h3, 4'h1, 4'hF, 24'h654321, 24'h0FEDCB, 24'h0);
    flow_op(3'h4, 4'h1, 4'h0, 24'h111111, 24'h222222, 24'h0FEDCB);
    for (int o = 5; o < 8; o++) begin
      flow_op(3'(o), 4'h0, 4'h0, 24'h333333, 24'h444444, 24'h555555);
    end
    finish_test("flow_ops");
  endtask : test_flow_ops

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d.", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Reset for two cycles, then every scenario in turn.
  initial begin
    i_rst_n = 1'h0;
    i_flags = '0;
    i_bit_valid = 1'h0;
    i_bit = '0;
    i_flow_valid = 1'h0;
    i_flow = '0;
    exp_pc = 24'h0;
    exp_push = 24'h0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'h1;
    test_carry_ops();
    test_store_ops();
    test_reg_select();
    test_conditions();
    test_flow_ops();
    give_verdict();
  end

endmodule : bcb_core_tb_top
